// [rtl/lrps_startup.sv]
// Power-on startup sequencer of the logic relay base module
`timescale 1ns/1ps
module lrps_startup import lrps_pkg::*; #(
  parameter int unsigned W          = IO_W,
  parameter int unsigned NEXP       = EXP_MAX,
  parameter longint unsigned CART_CYC   = INIT_CART_CYC,
  parameter longint unsigned PLAIN_CYC  = INIT_PLAIN_CYC,
  parameter longint unsigned SETTLE_CYC = EXP_SETTLE_CYC
) (
  input  wire logic            sys_clk,
  input  wire logic            rstn,
  input  wire logic            hasDisplay,
  input  wire lrps_cart_t      cartKind,
  input  wire logic            cartProgValid,
  input  wire lrps_keep_t      keepIn,
  input  wire logic            copyDone,
  input  wire logic [NEXP-1:0] expPresent,
  input  wire logic [NEXP-1:0] expOld,
  input  wire logic [NEXP-1:0] expBusy,
  input  wire logic            noProgAck,
  input  wire logic            scanTick,
  input  wire logic [W-1:0]    baseIn,
  input  wire logic [W-1:0]    expIn,
  input  wire logic [W-1:0]    progOut,
  output logic                 copyReq,
  output logic                 progClear,
  output logic                 retainLoad,
  output logic                 busyInd,
  output logic                 noProgShow,
  output logic                 lampGreen,
  output logic                 initDone,
  output logic                 initTimeout,
  output lrps_op_t             opState,
  output logic                 execEn,
  output logic [W-1:0]         inImage,
  output logic [W-1:0]         baseOut,
  output logic [W-1:0]         expOut
);
  typedef enum logic [2:0] {
    ST_SRC, ST_COPY, ST_EXP, ST_NOPROG, ST_SETTLE, ST_DONE
  } lrps_state_t;

  localparam int unsigned TW = 40;

  function automatic logic cartHasMem(input lrps_cart_t k);
    return (k == CART_MEM) || (k == CART_MEMBAT);
  endfunction : cartHasMem

  function automatic int unsigned countOnes(input logic [NEXP-1:0] v);
    int unsigned n;
    n = 0;
    for (int i = 0; i < NEXP; i++) begin
      n += int'(v[i]);
    end
    return n;
  endfunction : countOnes

  lrps_state_t   state_r, state_nxt;
  logic [TW-1:0] tmr_r, tmr_nxt;
  logic [TW-1:0] settle_r, settle_nxt;
  lrps_op_t      op_r, op_nxt;
  logic          progOk_r, progOk_nxt;
  logic          tout_r, tout_nxt;
  logic          retain_r, retain_nxt;
  logic          clear_r, clear_nxt;
  logic [NEXP-1:0] expSeen_r, expSeen_nxt;
  logic [TW-1:0] limit;
  logic          expWait;

  // Limit depends on whether the cartridge carries program memory
  assign limit = cartHasMem(cartKind) ? TW'(CART_CYC) : TW'(PLAIN_CYC);
  // Modules are only latched in ST_SRC at the start of init; ones powered later stay unseen
  assign expWait = |(expSeen_r & expBusy);

  always_comb begin
    state_nxt   = state_r;
    tmr_nxt     = tmr_r;
    settle_nxt  = settle_r;
    op_nxt      = op_r;
    progOk_nxt  = progOk_r;
    tout_nxt    = tout_r;
    retain_nxt  = 1'b0;
    clear_nxt   = 1'b0;
    expSeen_nxt = expSeen_r;
    if (state_r != ST_DONE && state_r != ST_NOPROG && tmr_r < limit) begin
      tmr_nxt = tmr_r + 1'b1;
    end
    case (state_r)
      ST_SRC: begin
        expSeen_nxt = expPresent;
        // A program half-entered at power loss is not trusted
        progOk_nxt = (keepIn.progValid && !keepIn.editing) || cartProgValid;
        clear_nxt  = keepIn.editing;
        if (cartProgValid) begin
          state_nxt = ST_COPY;
        end else begin
          state_nxt = ST_EXP;
        end
      end
      ST_COPY: begin
        if (copyDone) begin
          state_nxt = ST_EXP;
        end
      end
      ST_EXP: begin
        if (!progOk_r) begin
          op_nxt = OP_STOP;
          state_nxt = hasDisplay ? ST_NOPROG : ST_DONE;
        end else begin
          // Display-less units always start; others resume the saved state
          op_nxt     = hasDisplay ? keepIn.lastOp : OP_RUN;
          retain_nxt = 1'b1;
          settle_nxt = (countOnes(expSeen_r & expOld) >= OLD_EXP_LIMIT) ?
                       TW'(SETTLE_CYC) : '0;
          state_nxt  = ST_SETTLE;
        end
      end
      ST_NOPROG: begin
        if (noProgAck) begin
          state_nxt = ST_DONE;
        end
      end
      ST_SETTLE: begin
        if (settle_r != '0) begin
          settle_nxt = settle_r - 1'b1;
        end else if (!expWait) begin
          state_nxt = ST_DONE;
        end
      end
      ST_DONE: ;
      default: state_nxt = ST_SRC;
    endcase
    // Flags overrun of the documented bound rather than forcing completion
    if (state_r != ST_DONE && state_r != ST_NOPROG && tmr_r >= limit) begin
      tout_nxt = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_r   <= ST_SRC;
      tmr_r     <= '0;
      settle_r  <= '0;
      op_r      <= OP_STOP;
      progOk_r  <= 1'b0;
      tout_r    <= 1'b0;
      retain_r  <= 1'b0;
      clear_r   <= 1'b0;
      expSeen_r <= '0;
    end else begin
      state_r   <= state_nxt;
      tmr_r     <= tmr_nxt;
      settle_r  <= settle_nxt;
      op_r      <= op_nxt;
      progOk_r  <= progOk_nxt;
      tout_r    <= tout_nxt;
      retain_r  <= retain_nxt;
      clear_r   <= clear_nxt;
      expSeen_r <= expSeen_nxt;
    end
  end

  assign initDone    = (state_r == ST_DONE);
  assign busyInd     = !initDone && state_r != ST_NOPROG;
  assign noProgShow  = (state_r == ST_NOPROG);
  assign copyReq     = (state_r == ST_COPY);
  assign progClear   = clear_r;
  assign retainLoad  = retain_r;
  assign initTimeout = tout_r;
  assign opState     = initDone ? op_r : OP_STOP;
  assign execEn      = initDone && op_r == OP_RUN;
  assign lampGreen   = execEn;

  lrps_scan #(.W(W)) u_scan (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .scanTick (scanTick),
    .runEn    (execEn),
    .expReady (!expWait),
    .baseIn   (baseIn),
    .expIn    (expIn),
    .progOut  (progOut),
    .inImage  (inImage),
    .baseOut  (baseOut),
    .expOut   (expOut)
  );

  property p_busy_until_done;
    @(posedge sys_clk) disable iff (!rstn)
      (!initDone && !noProgShow) |-> (busyInd && !lampGreen && !execEn);
  endproperty
  a_busy_until_done: assert property (p_busy_until_done) else $error("busy not shown");

  property p_bound;
    @(posedge sys_clk) disable iff (!rstn)
      (tmr_r >= limit && !initDone && !noProgShow) |=> initTimeout;
  endproperty
  a_bound: assert property (p_bound) else $error("init bound check");

  property p_clear_edit;
    @(posedge sys_clk) disable iff (!rstn) (state_r == ST_SRC && keepIn.editing) |=> progClear;
  endproperty
  a_clear_edit: assert property (p_clear_edit) else $error("program not discarded");

  property p_nodisp_run;
    @(posedge sys_clk) disable iff (!rstn) (initDone && !hasDisplay && progOk_r) |-> lampGreen;
  endproperty
  a_nodisp_run: assert property (p_nodisp_run) else $error("no auto run");

  property p_noprog_stop;
    @(posedge sys_clk) disable iff (!rstn) noProgShow |-> !execEn;
  endproperty
  a_noprog_stop: assert property (p_noprog_stop) else $error("running without program");
endmodule : lrps_startup

// [pkg/lrps_pkg.sv]
// Package for the logic relay power-on startup sequencer
package lrps_pkg;

  localparam int unsigned CLK_HZ        = 25_000_000;
  localparam int unsigned INIT_MAX_CART_S  = 10;
  localparam int unsigned INIT_MAX_PLAIN_S = 9;
  localparam longint unsigned INIT_CART_CYC  = longint'(INIT_MAX_CART_S) * CLK_HZ;
  localparam longint unsigned INIT_PLAIN_CYC = longint'(INIT_MAX_PLAIN_S) * CLK_HZ;
  localparam int unsigned OLD_EXP_LIMIT = 3;
  localparam int unsigned EXP_SETTLE_MS = 500;
  localparam longint unsigned EXP_SETTLE_CYC =
    longint'(EXP_SETTLE_MS) * (CLK_HZ / 1000);
  localparam int unsigned IO_W          = 8;
  localparam int unsigned EXP_MAX       = 4;

  typedef enum logic [1:0] {
    CART_NONE,
    CART_MEM,
    CART_MEMBAT,
    CART_BAT
  } lrps_cart_t;

  typedef enum logic {
    OP_STOP,
    OP_RUN
  } lrps_op_t;

  // Retained state kept across power loss by the backed-up store
  typedef struct packed {
    logic     progValid;
    logic     editing;
    lrps_op_t lastOp;
  } lrps_keep_t;

endpackage : lrps_pkg

// [rtl/lrps_scan.sv]
// Scan loop: one input sample and one output update per scan tick
`timescale 1ns/1ps
module lrps_scan import lrps_pkg::*; #(
  parameter int unsigned W = IO_W
) (
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  input  wire logic         scanTick,
  input  wire logic         runEn,
  input  wire logic         expReady,
  input  wire logic [W-1:0] baseIn,
  input  wire logic [W-1:0] expIn,
  input  wire logic [W-1:0] progOut,
  output logic      [W-1:0] inImage,
  output logic      [W-1:0] baseOut,
  output logic      [W-1:0] expOut
);
  logic [W-1:0] inImage_r, inImage_nxt;
  logic [W-1:0] baseOut_r, baseOut_nxt;
  logic [W-1:0] expOut_r,  expOut_nxt;

  always_comb begin
    inImage_nxt = inImage_r;
    baseOut_nxt = baseOut_r;
    expOut_nxt  = expOut_r;
    if (!runEn) begin
      // No sampling, outputs held off while stopped
      baseOut_nxt = '0;
      expOut_nxt  = '0;
    end else begin
      if (scanTick) begin
        // Outputs from last scan's image land one scan after the input
        inImage_nxt = baseIn | (expReady ? expIn : '0);
        baseOut_nxt = progOut;
        expOut_nxt  = progOut;
      end
      // A module back in init loses its outputs at once, not at the next scan
      if (!expReady) begin
        expOut_nxt = '0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      inImage_r <= '0;
      baseOut_r <= '0;
      expOut_r  <= '0;
    end else begin
      inImage_r <= inImage_nxt;
      baseOut_r <= baseOut_nxt;
      expOut_r  <= expOut_nxt;
    end
  end

  assign inImage = inImage_r;
  assign baseOut = baseOut_r;
  assign expOut  = expOut_r;

  property p_stop_off;
    @(posedge sys_clk) disable iff (!rstn) !runEn |=> (baseOut == '0 && expOut == '0);
  endproperty
  a_stop_off: assert property (p_stop_off) else $error("outputs on while stopped");

  property p_exp_off;
    @(posedge sys_clk) disable iff (!rstn) !expReady |=> expOut == '0;
  endproperty
  a_exp_off: assert property (p_exp_off) else $error("expansion output on in init");

  property p_scan_update;
    @(posedge sys_clk) disable iff (!rstn)
      (runEn && scanTick) |=> baseOut == $past(progOut);
  endproperty
  a_scan_update: assert property (p_scan_update) else $error("output not updated on scan");
endmodule : lrps_scan

// [test/lrps_partner_model.sv]
// Cartridge and expansion side model for the startup sequencer
`timescale 1ns/1ps
module lrps_partner_model import lrps_pkg::*; #(
  parameter int unsigned NEXP     = EXP_MAX,
  parameter int unsigned COPY_CYC = 5,
  parameter int unsigned BUSY_CYC = 12
) (
  input  wire logic            sys_clk,
  input  wire logic            rstn,
  input  wire logic            copyReq,
  input  wire logic            copyHold,
  output logic                 copyDone,
  output logic [NEXP-1:0]      expBusy
);
  int unsigned cpyCnt_r;
  int unsigned busyCnt_r;
  // Modules are powered with the base, so busy starts at reset
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cpyCnt_r  <= 0;
      busyCnt_r <= 0;
    end else begin
      cpyCnt_r  <= copyReq ? ((cpyCnt_r < COPY_CYC) ? cpyCnt_r + 1 : cpyCnt_r) : 0;
      busyCnt_r <= (busyCnt_r < BUSY_CYC) ? busyCnt_r + 1 : busyCnt_r;
    end
  end
  // Copy answers slowly; a hold stretches it to push a boot past its bound
  assign copyDone = copyReq && !copyHold && (cpyCnt_r == COPY_CYC);
  // Busy while the module itself initializes
  assign expBusy  = (busyCnt_r < BUSY_CYC) ? {NEXP{1'b1}} : {NEXP{1'b0}};
endmodule : lrps_partner_model

// [test/logic_relay_power_on_startup_tb_top.sv]
// Testbench for the power-on startup sequencer
`timescale 1ns/1ps
module logic_relay_power_on_startup_tb_top import lrps_pkg::*;;
  localparam int unsigned CC = 200;
  localparam int unsigned PC = 180;
  logic sys_clk = 0, rstn = 0, hasDisplay = 1, copyDone, noProgAck = 0, scanTick = 0;
  logic cartProgValid = 0;
  logic copyHold = 0;
  lrps_cart_t cartKind = CART_NONE;
  lrps_keep_t keepIn = '0;
  logic [3:0] expPresent = 4'h1, expOld = 4'h0, expBusy;
  logic [7:0] baseIn = 8'h00, expIn = 8'h00, progOut = 8'h00;
  logic copyReq, progClear, retainLoad, busyInd, noProgShow, lampGreen, initDone, initTimeout;
  lrps_op_t opState;
  logic execEn;
  logic [7:0] inImage, baseOut, expOut;
  int n_fail = 0, compares = 0, cyc;
  logic sCopy, sClr, sRet, sNo;
  always #20 sys_clk = ~sys_clk;
  lrps_startup #(.W(8), .NEXP(4), .CART_CYC(CC), .PLAIN_CYC(PC), .SETTLE_CYC(20))
    lrps_startup_i (.sys_clk(sys_clk), .rstn(rstn), .hasDisplay(hasDisplay),
    .cartKind(cartKind), .cartProgValid(cartProgValid), .keepIn(keepIn),
    .copyDone(copyDone), .expPresent(expPresent), .expOld(expOld), .expBusy(expBusy),
    .noProgAck(noProgAck), .scanTick(scanTick), .baseIn(baseIn), .expIn(expIn),
    .progOut(progOut), .copyReq(copyReq), .progClear(progClear),
    .retainLoad(retainLoad), .busyInd(busyInd), .noProgShow(noProgShow),
    .lampGreen(lampGreen), .initDone(initDone), .initTimeout(initTimeout),
    .opState(opState), .execEn(execEn), .inImage(inImage), .baseOut(baseOut),
    .expOut(expOut));
  lrps_partner_model #(.NEXP(4)) lrps_partner_model_i (.sys_clk(sys_clk), .rstn(rstn),
    .copyReq(copyReq), .copyHold(copyHold), .copyDone(copyDone), .expBusy(expBusy));
  always @(posedge sys_clk) begin
    sCopy <= sCopy | copyReq;
    sClr  <= sClr | progClear;
    sRet  <= sRet | retainLoad;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One power-up: reset held 8 cycles, then wait for done, acking a no-program report
  task automatic boot(input lrps_cart_t ck, input logic cp, input lrps_keep_t kp,
                      input logic disp, input logic [3:0] old);
    @(negedge sys_clk);
    rstn = 0;
    cartKind = ck;
    cartProgValid = cp;
    keepIn = kp;
    hasDisplay = disp;
    expPresent = old | 4'h1;
    expOld = old;
    sCopy = 0; sClr = 0; sRet = 0; sNo = 0;
    repeat (8) @(negedge sys_clk);
    chk(busyInd, 1'b1);
    rstn = 1;
    for (cyc = 0; cyc < 400 && initDone !== 1'b1; cyc++) begin
      @(negedge sys_clk);
      noProgAck = (noProgShow === 1'b1) && !sNo;
      if (noProgShow === 1'b1) sNo = 1;
    end
    noProgAck = 0;
    chk(initDone, 1'b1);
    chk(busyInd, 1'b0);
  endtask : boot
  task automatic scan(input logic [7:0] bi, input logic [7:0] po);
    baseIn = bi;
    progOut = po;
    scanTick = 1;
    @(negedge sys_clk);
    scanTick = 0;
    repeat (2) @(negedge sys_clk);
  endtask : scan
  task automatic report_and_stop;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  initial begin
    #200000;
    n_fail++;
    report_and_stop();
  end
  initial begin
    boot(CART_MEM, 1, '{1'b0, 1'b0, OP_RUN}, 1, 4'h0);
    expIn = 8'h10;
    chk(sCopy, 1'b1);
    chk(cyc <= CC, 1'b1);
    chk(initTimeout, 1'b0);
    chk(opState, OP_RUN);
    chk(sRet, 1'b1);
    scan(8'hA5, 8'h3C);
    chk(inImage, 8'hB5);
    chk(baseOut, 8'h3C);
    chk(expOut, 8'h3C);
    boot(CART_MEMBAT, 1, '{1'b1, 1'b0, OP_STOP}, 1, 4'h0);
    chk(cyc <= CC, 1'b1);
    chk(opState, OP_STOP);
    boot(CART_BAT, 0, '{1'b1, 1'b0, OP_STOP}, 1, 4'h0);
    chk(sCopy, 1'b0);
    chk(cyc <= PC, 1'b1);
    chk(execEn, 1'b0);
    scan(8'h5A, 8'hFF);
    chk(inImage, 8'h00);
    chk(baseOut, 8'h00);
    chk(expOut, 8'h00);
    boot(CART_NONE, 0, '{1'b1, 1'b0, OP_STOP}, 0, 4'h0);
    chk(cyc <= PC, 1'b1);
    chk(opState, OP_RUN);
    chk(lampGreen, 1'b1);
    boot(CART_NONE, 0, '{1'b1, 1'b1, OP_RUN}, 1, 4'h0);
    chk(sClr, 1'b1);
    chk(sNo, 1'b1);
    chk(execEn, 1'b0);
    boot(CART_NONE, 0, '{1'b1, 1'b0, OP_RUN}, 1, 4'h7);
    chk(cyc >= 20, 1'b1);
    chk(initTimeout, 1'b0);
    // Copy held back past the bound: the overrun must be flagged
    copyHold = 1;
    fork
      boot(CART_MEMBAT, 1, '{1'b0, 1'b0, OP_RUN}, 1, 4'h0);
      begin
        repeat (CC + 20) @(negedge sys_clk);
        copyHold = 0;
      end
    join
    chk(initTimeout, 1'b1);
    chk(cyc > CC, 1'b1);
    chk(sCopy, 1'b1);
    report_and_stop();
  end
endmodule : logic_relay_power_on_startup_tb_top
